// File: src/rij_map.svh
// constants for the relative and indirect jump unit
// Function
// - opcode 38 branches relative when carry set
// - opcode 30 branches relative when carry clear
// - opcode 28 branches relative when zero set
// - opcode 20 branches relative when zero clear
// - relative reach is -126 to +129 bytes
// - target is opcode address plus two plus displacement
// - taken relative branch lasts 12 states: 4,3,5
// - untaken relative branch lasts 7 states: 4,3
// - untaken branch continues after displacement byte
// - E9 loads pointer pair in 4 states
// - DD E9 loads first index in 4,4
// - FD E9 loads second index, same timing
// - taken jump fetches next from new counter
`ifndef RIJ_MAP_SVH
`define RIJ_MAP_SVH
`define RIJ_OP_BR_CARRY 8'h38
`define RIJ_OP_BR_NOCARRY 8'h30
`define RIJ_OP_BR_ZERO 8'h28
`define RIJ_OP_BR_NONZERO 8'h20
`define RIJ_OP_PTR_JUMP 8'hE9
`define RIJ_PFX_FIRST 8'hDD
`define RIJ_PFX_SECOND 8'hFD
`define RIJ_OPC_STATES 3'h4
`define RIJ_DISP_STATES 3'h3
`define RIJ_ADD_STATES 3'h5
`define RIJ_PFX_STATES 3'h4
`define RIJ_REL_STEP 16'h0002
`define RIJ_PC_RESET 16'h0000
`endif

// File: src/rij_pkg.sv
// types for the relative and indirect jump unit
package rij_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PFX = 3'b001,
		ST_OPC = 3'b010,
		ST_DISP = 3'b011,
		ST_ADD = 3'b100
	} rij_state_t;
	typedef enum logic [1:0] {
		SRC_POINTER = 2'b00,
		SRC_FIRST = 2'b01,
		SRC_SECOND = 2'b10
	} rij_src_t;
endpackage

// File: src/rij_cond.sv
// condition test and target adder for relative branches
`timescale 1ns/1ps
`default_nettype none
`include "rij_map.svh"
module rij_cond
	import rij_pkg::*;
(
	// opcode and flags
	input wire logic [7:0] opcode,
	input wire logic carry_flag,
	input wire logic zero_flag,
	// address arithmetic
	input wire logic [15:0] op_addr,
	input wire logic [7:0] disp,
	output logic is_rel,
	output logic taken,
	output logic [15:0] seq_addr,
	output logic [15:0] target
);
	function automatic logic [15:0] sext8(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction
	always_comb begin
		is_rel = 1'b1;
		taken = 1'b0;
		case (opcode)
			`RIJ_OP_BR_CARRY: taken = carry_flag;
			`RIJ_OP_BR_NOCARRY: taken = !carry_flag;
			`RIJ_OP_BR_ZERO: taken = zero_flag;
			`RIJ_OP_BR_NONZERO: taken = !zero_flag;
			default: is_rel = 1'b0;
		endcase
	end
	// counter already past both bytes, so reach is -126..+129 from opcode
	assign seq_addr = op_addr + `RIJ_REL_STEP;
	assign target = seq_addr + sext8(disp);
endmodule // rij_cond
`default_nettype wire

// File: src/rij_unit.sv
// relative and register-indirect jump execution unit
`timescale 1ns/1ps
`default_nettype none
`include "rij_map.svh"
module rij_unit
	import rij_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// instruction stream
	input wire logic START,
	input wire logic [15:0] OP_ADDR,
	input wire logic [7:0] PREFIX,
	input wire logic PREFIX_VALID,
	input wire logic [7:0] OPCODE,
	input wire logic [7:0] DISP,
	// machine state
	input wire logic CARRY_FLAG,
	input wire logic ZERO_FLAG,
	input wire logic [15:0] MAIN_POINTER_PAIR,
	input wire logic [15:0] FIRST_INDEX_REG,
	input wire logic [15:0] SECOND_INDEX_REG,
	// results
	output logic BUSY,
	output logic DONE,
	output logic PC_LOAD,
	output logic [15:0] NEXT_PC,
	output logic [4:0] STATE_COUNT,
	output logic [1:0] MCYCLE_COUNT,
	output logic [7:0] FLAGS_OUT
);
	rij_state_t state;
	logic [2:0] tcnt;
	logic [7:0] opc, disp;
	logic [15:0] op_addr;
	logic carry, zero, is_rel, taken, rel_ok, ptr_ok;
	logic [15:0] seq_addr, target;
	logic [15:0] next_pc_src;
	logic [2:0] phase_len;

	rij_cond u_cond (
		.opcode(opc),
		.carry_flag(carry),
		.zero_flag(zero),
		.op_addr(op_addr),
		.disp(disp),
		.is_rel(is_rel),
		.taken(taken),
		.seq_addr(seq_addr),
		.target(target)
	);

	// unsupported opcodes are accepted only when recognised
	assign rel_ok = START && !PREFIX_VALID &&
		(OPCODE == `RIJ_OP_BR_CARRY || OPCODE == `RIJ_OP_BR_NOCARRY ||
		OPCODE == `RIJ_OP_BR_ZERO || OPCODE == `RIJ_OP_BR_NONZERO);
	assign ptr_ok = START && OPCODE == `RIJ_OP_PTR_JUMP && (!PREFIX_VALID ||
		PREFIX == `RIJ_PFX_FIRST || PREFIX == `RIJ_PFX_SECOND);
	assign BUSY = state != ST_IDLE;

	// operand capture; flags copied at start so mid-instruction change is moot
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			opc <= 8'h00;
			disp <= 8'h00;
			op_addr <= `RIJ_PC_RESET;
			carry <= 1'b0;
			zero <= 1'b0;
			next_pc_src <= `RIJ_PC_RESET;
		end else if (state == ST_IDLE && (rel_ok || ptr_ok)) begin
			opc <= OPCODE;
			disp <= DISP;
			op_addr <= OP_ADDR;
			carry <= CARRY_FLAG;
			zero <= ZERO_FLAG;
			if (!PREFIX_VALID)
				next_pc_src <= MAIN_POINTER_PAIR;
			else if (PREFIX == `RIJ_PFX_FIRST)
				next_pc_src <= FIRST_INDEX_REG;
			else
				next_pc_src <= SECOND_INDEX_REG;
		end
	end

	always_comb begin
		case (state)
			ST_PFX: phase_len = `RIJ_PFX_STATES;
			ST_OPC: phase_len = `RIJ_OPC_STATES;
			ST_DISP: phase_len = `RIJ_DISP_STATES;
			ST_ADD: phase_len = `RIJ_ADD_STATES;
			default: phase_len = 3'h1;
		endcase
	end

	// one clock per state; machine cycles sequenced by phase length
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state <= ST_IDLE;
			tcnt <= 3'h0;
		end else if (state == ST_IDLE) begin
			tcnt <= 3'h0;
			if (rel_ok || ptr_ok)
				state <= PREFIX_VALID ? ST_PFX : ST_OPC;
		end else if (tcnt != phase_len - 3'h1) begin
			tcnt <= tcnt + 3'h1;
		end else begin
			tcnt <= 3'h0;
			case (state)
				ST_PFX: state <= ST_OPC;
				ST_OPC: state <= is_rel ? ST_DISP : ST_IDLE;
				ST_DISP: state <= taken ? ST_ADD : ST_IDLE;
				ST_ADD: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	logic last_t;
	assign last_t = BUSY && tcnt == phase_len - 3'h1;

	// counters of states and machine cycles for the current instruction
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			STATE_COUNT <= 5'h00;
			MCYCLE_COUNT <= 2'h0;
		end else if (state == ST_IDLE && (rel_ok || ptr_ok)) begin
			STATE_COUNT <= 5'h00;
			MCYCLE_COUNT <= 2'h0;
		end else if (BUSY) begin
			STATE_COUNT <= STATE_COUNT + 5'h01;
			if (last_t)
				MCYCLE_COUNT <= MCYCLE_COUNT + 2'h1;
		end
	end

	// result pulse and counter; held until next completion
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			DONE <= 1'b0;
			PC_LOAD <= 1'b0;
			NEXT_PC <= `RIJ_PC_RESET;
		end else begin
			DONE <= 1'b0;
			PC_LOAD <= 1'b0;
			if (last_t && state == ST_OPC && !is_rel) begin
				DONE <= 1'b1;
				PC_LOAD <= 1'b1;
				NEXT_PC <= next_pc_src;
			end else if (last_t && state == ST_DISP && !taken) begin
				DONE <= 1'b1;
				NEXT_PC <= seq_addr;
			end else if (last_t && state == ST_ADD) begin
				DONE <= 1'b1;
				PC_LOAD <= 1'b1;
				NEXT_PC <= target;
			end
		end
	end

	// flags pass through untouched
	assign FLAGS_OUT = {1'b0, ZERO_FLAG, 5'h00, CARRY_FLAG};

	logic [4:0] run_len;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			run_len <= 5'h00;
		else if (BUSY)
			run_len <= run_len + 5'h01;
		else
			run_len <= 5'h00;
	end

	a_taken_len: assert property (@(posedge CORE_CLK) disable iff (RST)
		DONE && PC_LOAD && $past(state) == ST_ADD |-> $past(run_len) == 5'h0B)
		else $error("taken relative branch not 12 states");
	a_untaken_len: assert property (@(posedge CORE_CLK) disable iff (RST)
		DONE && !PC_LOAD |-> $past(run_len) == 5'h06)
		else $error("untaken relative branch not 7 states");
	a_ptr_len: assert property (@(posedge CORE_CLK) disable iff (RST)
		state == ST_IDLE && ptr_ok && !PREFIX_VALID |=> state == ST_OPC ##4 DONE && PC_LOAD)
		else $error("pointer jump not 4 states");
	a_idx_len: assert property (@(posedge CORE_CLK) disable iff (RST)
		state == ST_IDLE && ptr_ok && PREFIX_VALID |=> (state == ST_PFX)[*4] ##5 DONE)
		else $error("index jump not 8 states");
	a_idx_value: assert property (@(posedge CORE_CLK) disable iff (RST)
		state == ST_IDLE && ptr_ok && PREFIX == `RIJ_PFX_SECOND && PREFIX_VALID
		|-> ##9 NEXT_PC == $past(SECOND_INDEX_REG, 9))
		else $error("second index not loaded");
	a_seq_addr: assert property (@(posedge CORE_CLK) disable iff (RST)
		DONE && !PC_LOAD |-> NEXT_PC == op_addr + 16'h0002)
		else $error("untaken branch wrong next address");
	a_target: assert property (@(posedge CORE_CLK) disable iff (RST)
		DONE && PC_LOAD && $past(state) == ST_ADD
		|-> NEXT_PC == op_addr + 16'h0002 + {{8{disp[7]}}, disp})
		else $error("relative target wrong");
	a_carry_dec: assert property (@(posedge CORE_CLK) disable iff (RST)
		state == ST_DISP && opc == `RIJ_OP_BR_CARRY |-> taken == carry)
		else $error("carry branch decision wrong");
	a_zero_dec: assert property (@(posedge CORE_CLK) disable iff (RST)
		state == ST_DISP && opc == `RIJ_OP_BR_NONZERO |-> taken == !zero)
		else $error("nonzero branch decision wrong");
	a_flags_kept: assert property (@(posedge CORE_CLK) disable iff (RST)
		FLAGS_OUT[0] == CARRY_FLAG && FLAGS_OUT[6] == ZERO_FLAG)
		else $error("flag altered");
	// reported counts must agree with the instruction that just ended
	a_taken_counts: assert property (@(posedge CORE_CLK) disable iff (RST)
		DONE && PC_LOAD && $past(state) == ST_ADD |-> STATE_COUNT == 5'h0C && MCYCLE_COUNT == 2'h3)
		else $error("taken branch counts wrong");
	a_fall_counts: assert property (@(posedge CORE_CLK) disable iff (RST)
		DONE && !PC_LOAD |-> STATE_COUNT == 5'h07 && MCYCLE_COUNT == 2'h2)
		else $error("untaken branch counts wrong");
	a_ptr_value: assert property (@(posedge CORE_CLK) disable iff (RST)
		state == ST_IDLE && ptr_ok && !PREFIX_VALID
		|-> ##5 PC_LOAD && NEXT_PC == $past(MAIN_POINTER_PAIR, 5))
		else $error("pointer pair not loaded");
	a_first_value: assert property (@(posedge CORE_CLK) disable iff (RST)
		state == ST_IDLE && ptr_ok && PREFIX == `RIJ_PFX_FIRST && PREFIX_VALID
		|-> ##9 PC_LOAD && NEXT_PC == $past(FIRST_INDEX_REG, 9))
		else $error("first index not loaded");

	c_rel_taken: cover property (@(posedge CORE_CLK) DONE && PC_LOAD && $past(state) == ST_ADD);
	c_rel_fall: cover property (@(posedge CORE_CLK) DONE && !PC_LOAD);
	c_idx_jump: cover property (@(posedge CORE_CLK) state == ST_PFX ##4 state == ST_OPC);
	c_ptr_jump: cover property (@(posedge CORE_CLK) state == ST_IDLE && ptr_ok && !PREFIX_VALID);
	c_back_to_back: cover property (@(posedge CORE_CLK) DONE ##1 BUSY);
endmodule // rij_unit
`default_nettype wire

// File: dv/rij_unit_bench.sv
// self-checking bench for the relative and indirect jump unit
`timescale 1ns/1ps
`default_nettype none
`include "rij_map.svh"
module rij_unit_bench
	import rij_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, pv = 1'b0, cf = 1'b0, zf = 1'b0;
	logic [15:0] addr = 16'h0000, ptr_pair = 16'h0000, idx_first = 16'h0000, idx_second = 16'h0000;
	logic [7:0] pfx = 8'h00, op = 8'h00, disp = 8'h00;
	logic busy, done, pc_load;
	logic [15:0] next_pc;
	logic [4:0] st_cnt;
	logic [1:0] mc_cnt;
	logic [7:0] flags;
	logic [31:0] ops = 32'h3830_2820;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;

	always #20 clk = ~clk;

	rij_unit u_rij_unit (.CORE_CLK(clk), .RST(rst), .START(start), .OP_ADDR(addr),
		.PREFIX(pfx), .PREFIX_VALID(pv), .OPCODE(op), .DISP(disp), .CARRY_FLAG(cf),
		.ZERO_FLAG(zf), .MAIN_POINTER_PAIR(ptr_pair), .FIRST_INDEX_REG(idx_first),
		.SECOND_INDEX_REG(idx_second), .BUSY(busy), .DONE(done), .PC_LOAD(pc_load),
		.NEXT_PC(next_pc), .STATE_COUNT(st_cnt), .MCYCLE_COUNT(mc_cnt), .FLAGS_OUT(flags));

	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// a hang ends the run as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			print_verdict();
		end
	end

	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// offer one instruction; accepted at the next edge since busy is low
	task launch(input logic p_v, input logic [7:0] p, input logic [7:0] o,
		input logic [7:0] d, input logic c, input logic z);
		pv = p_v;
		pfx = p;
		op = o;
		disp = d;
		cf = c;
		zf = z;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
	endtask

	// n0 is the cycle count already spent since acceptance
	task finish(input int n0, input logic [15:0] exp_pc, input logic exp_ld, input int exp_n);
		int n;
		int mc;
		n = n0;
		mc = (exp_n == 13) ? 3 : ((exp_n == 5) ? 1 : 2);
		while (done !== 1'b1 && n < 30) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("cycles", exp_n[15:0], n[15:0]);
		chk("next_pc", exp_pc, next_pc);
		chk("pc_load", {15'h0000, exp_ld}, {15'h0000, pc_load});
		chk("flags", {8'h00, 1'b0, zf, 5'h00, cf}, {8'h00, flags});
		chk("states", 16'(exp_n - 1), {11'h000, st_cnt});
		chk("mcycles", 16'(mc), {14'h0000, mc_cnt});
	endtask

	task run(input logic p_v, input logic [7:0] p, input logic [7:0] o, input logic [7:0] d,
		input logic c, input logic z, input logic [15:0] exp_pc, input logic exp_ld, input int exp_n);
		launch(p_v, p, o, d, c, z);
		finish(1, exp_pc, exp_ld, exp_n);
	endtask

	// every condition code both ways, back to back; untested flag set opposite
	task cond_branches;
		logic f, tk;
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 2; j++) begin
				f = j[0];
				tk = (i % 2 == 0) ? f : ~f;
				addr = 16'h0480;
				run(1'b0, 8'h00, ops[31 - 8 * i -: 8], 8'hFA, (i < 2) ? f : ~f, (i < 2) ? ~f : f,
					tk ? 16'h047C : 16'h0482, tk, tk ? 13 : 8);
			end
		end
	endtask

	// extremes of the displacement and wrap of the 16-bit counter
	task reach;
		addr = 16'h1000;
		run(1'b0, 8'h00, `RIJ_OP_BR_CARRY, 8'h80, 1'b1, 1'b0, 16'h0F82, 1'b1, 13);
		run(1'b0, 8'h00, `RIJ_OP_BR_CARRY, 8'h7F, 1'b1, 1'b0, 16'h1081, 1'b1, 13);
		addr = 16'hFFF0;
		run(1'b0, 8'h00, `RIJ_OP_BR_NOCARRY, 8'h7F, 1'b0, 1'b1, 16'h0071, 1'b1, 13);
	endtask

	task indirect;
		ptr_pair = 16'h4800;
		idx_first = 16'h5A21;
		idx_second = 16'hC3B4;
		run(1'b0, 8'h00, `RIJ_OP_PTR_JUMP, 8'h00, 1'b0, 1'b1, 16'h4800, 1'b1, 5);
		run(1'b1, `RIJ_PFX_FIRST, `RIJ_OP_PTR_JUMP, 8'h00, 1'b1, 1'b0, 16'h5A21, 1'b1, 9);
		run(1'b1, `RIJ_PFX_SECOND, `RIJ_OP_PTR_JUMP, 8'h00, 1'b1, 1'b1, 16'hC3B4, 1'b1, 9);
	endtask

	// prefixed relative and unknown opcode ignored; new offers ignored while busy
	task refused;
		pv = 1'b1;
		pfx = `RIJ_PFX_FIRST;
		op = `RIJ_OP_BR_CARRY;
		start = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("busy", 16'h0000, {15'h0000, busy});
		pv = 1'b0;
		op = 8'h00;
		repeat (3) @(posedge clk);
		#1;
		chk("busy", 16'h0000, {15'h0000, busy});
		ptr_pair = 16'h2222;
		launch(1'b0, 8'h00, `RIJ_OP_PTR_JUMP, 8'h00, 1'b0, 1'b0);
		ptr_pair = 16'h3333;
		op = `RIJ_OP_BR_NONZERO;
		start = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		start = 1'b0;
		finish(3, 16'h2222, 1'b1, 5);
		@(posedge clk);
		#1;
		chk("done", 16'h0000, {15'h0000, done});
		chk("next_pc", 16'h2222, next_pc);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		#1;
		chk("next_pc", `RIJ_PC_RESET, next_pc);
		rst = 1'b0;
		cond_branches();
		reach();
		indirect();
		refused();
		print_verdict();
	end
endmodule // rij_unit_bench
`default_nettype wire
